//--- texdec_consts.svh
`ifndef TEXDEC_CONSTS_SVH
`define TEXDEC_CONSTS_SVH

// ----------------------------------------------------------------
// Register map, byte addresses on the AXI4-Lite slave
// ----------------------------------------------------------------
`define REG_CTRL      8'h00
`define REG_COUNT     8'h04
`define REG_MODE      8'h08
`define CTRL_EN_BIT   0
`define CTRL_EN_RST   1'b1
`define RESP_OKAY     2'b00
`define RESP_SLVERR   2'b10

// ----------------------------------------------------------------
// Block layout
// ----------------------------------------------------------------
`define MODE_BIT_HI   127
`define MODE_BIT_MID  126
`define MODE_BIT_LO   125
`define COL_W         15
`define HI_C0_LSB     96
`define HI_C1_LSB     111
`define QUAD_COL_LSB  64
`define MIX_FLAG_BIT  124
`define MIX_G3_BIT    126
`define MIX_G1_BIT    125
`define MIX_G0_XOR    1
`define MIX_G2_XOR    33

// ----------------------------------------------------------------
// Decode constants and timing
// ----------------------------------------------------------------
`define ALPHA_OPAQUE  8'hff
`define HI_BLACK_SEL  3'h7
`define HI_STEPS      11'd6
`define HI_ROUND      11'd3
`define DEC_LATENCY   2

`endif

//--- texdec_pkg.sv
package texdec_pkg;

  // Block modes as seen by the decoder.
  typedef enum logic [1:0] {
    hi_precision_mode       = 2'h0,
    direct_four_colour_mode = 2'h1,
    split_pair_mode         = 2'h2,
    unsupported_mode        = 2'h3
  } mode_t;

  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } rgb_t;

  typedef struct packed {
    logic [7:0] a;
    rgb_t       c;
  } argb_t;

  typedef struct packed {
    logic         valid;
    logic [127:0] blk;
    logic [4:0]   index;
  } texel_req_t;

  typedef struct packed {
    logic  valid;
    argb_t argb;
  } texel_rsp_t;

  typedef struct packed {
    texel_req_t s1;
    texel_rsp_t rsp;
    logic       enable;
    logic [31:0] count;
    mode_t      last_mode;
    logic       awready;
    logic       wready;
    logic       aw_held;
    logic       w_held;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic       bvalid;
    logic [1:0] bresp;
    logic       arready;
    logic       rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } top_state_t;

  // Five-bit channel to eight bits by high-order replication.
  function automatic logic [7:0] widen5(input logic [4:0] c);
    return {c, c[4:2]};
  endfunction

  function automatic rgb_t widen555(input logic [14:0] f);
    return '{widen5(f[14:10]), widen5(f[9:5]), widen5(f[4:0])};
  endfunction

endpackage

//--- texel_colour_decode.sv
`include "texdec_consts.svh"

// Combinational decode of one texel out of one block.
module texel_colour_decode (
  // Encoded block and texel number
  input  wire logic [127:0]        blk,
  input  wire logic [4:0]          index,
  // Decoded texel
  output texdec_pkg::argb_t        argb,
  output texdec_pkg::mode_t        mode,
  output logic [2:0]               sel
);

  // ----------------------------------------------------------------
  // Arithmetic helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] lerp6(input logic [7:0] c0, input logic [7:0] c1,
                                       input logic [2:0] k);
    logic [10:0] s;
    s = (`HI_STEPS - 11'(k)) * 11'(c0) + 11'(k) * 11'(c1) + `HI_ROUND;
    return 8'(s / `HI_STEPS);
  endfunction

  function automatic logic [7:0] lerp3(input logic [7:0] a, input logic [7:0] b);
    logic [9:0] s;
    s = 10'({a, 1'b0}) + 10'(b) + 10'd1;
    return 8'(s / 10'd3);
  endfunction

  function automatic logic [7:0] half(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = 9'(a) + 9'(b) + 9'd1;
    return s[8:1];
  endfunction

  // Green widened from five bits plus a separately carried low bit.
  function automatic logic [7:0] g565(input logic [4:0] g, input logic lsb);
    return {g, lsb, g[4:3]};
  endfunction

  // ----------------------------------------------------------------
  // Mode, selector and colour table
  // ----------------------------------------------------------------
  logic [6:0]              idx3;
  texdec_pkg::rgb_t [3:0]  col;
  texdec_pkg::rgb_t        lo;
  texdec_pkg::rgb_t        hi;
  texdec_pkg::rgb_t        c0;
  texdec_pkg::rgb_t        c1;
  logic [3:0]              glsb;
  logic                    flag;

  // The mode is fixed first; the rest of the decode hangs on it.
  always_comb begin
    idx3 = 7'(index) * 7'd3;
    flag = blk[`MIX_FLAG_BIT];
    glsb = {blk[`MIX_G3_BIT], blk[`MIX_G2_XOR] ^ blk[`MIX_G3_BIT],
            blk[`MIX_G1_BIT], blk[`MIX_G0_XOR] ^ blk[`MIX_G1_BIT]};
    if (blk[`MODE_BIT_HI]) begin
      mode = texdec_pkg::split_pair_mode;
    end else if (!blk[`MODE_BIT_MID]) begin
      mode = texdec_pkg::hi_precision_mode;
    end else if (!blk[`MODE_BIT_LO]) begin
      mode = texdec_pkg::direct_four_colour_mode;
    end else begin
      mode = texdec_pkg::unsupported_mode;
    end
    if (mode == texdec_pkg::hi_precision_mode) begin
      sel = blk[idx3 +: 3];
    end else begin
      sel = {1'b0, blk[{index, 1'b0} +: 2]};
    end
    c0 = texdec_pkg::widen555(blk[`HI_C0_LSB +: `COL_W]);
    c1 = texdec_pkg::widen555(blk[`HI_C1_LSB +: `COL_W]);
    for (int n = 0; n < 4; n++) begin
      col[n] = texdec_pkg::widen555(blk[`QUAD_COL_LSB + n * `COL_W +: `COL_W]);
      // Split blocks carry a sixth green bit; with the flag set only 1 and 3 have one.
      if (mode == texdec_pkg::split_pair_mode && (!flag || n[0])) begin
        col[n].g = g565(blk[`QUAD_COL_LSB + n * `COL_W + 5 +: 5], glsb[n]);
      end
    end
    lo = index[4] ? col[2] : col[0];
    hi = index[4] ? col[3] : col[1];
    argb = '0;
    case (mode)
      texdec_pkg::hi_precision_mode: begin
        if (sel != `HI_BLACK_SEL) begin
          argb.a = `ALPHA_OPAQUE;
          argb.c = '{lerp6(c0.r, c1.r, sel), lerp6(c0.g, c1.g, sel),
                     lerp6(c0.b, c1.b, sel)};
        end
      end
      texdec_pkg::direct_four_colour_mode: begin
        argb = '{`ALPHA_OPAQUE, col[sel[1:0]]};
      end
      texdec_pkg::split_pair_mode: begin
        argb.a = `ALPHA_OPAQUE;
        if (!flag) begin
          case (sel[1:0])
            2'h0: argb.c = lo;
            2'h1: argb.c = '{lerp3(lo.r, hi.r), lerp3(lo.g, hi.g), lerp3(lo.b, hi.b)};
            2'h2: argb.c = '{lerp3(hi.r, lo.r), lerp3(hi.g, lo.g), lerp3(hi.b, lo.b)};
            default: argb.c = hi;
          endcase
        end else begin
          case (sel[1:0])
            2'h0: argb.c = lo;
            2'h1: argb.c = '{half(lo.r, hi.r), half(lo.g, hi.g), half(lo.b, hi.b)};
            2'h2: argb.c = hi;
            default: argb = '0;
          endcase
        end
      end
      default: argb = '0;
    endcase
  end

endmodule // texel_colour_decode

//--- texel_decoder_top.sv
`include "texdec_consts.svh"

module texel_decoder_top (
  // Clock and reset
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  // AXI4-Lite write address
  input  wire logic [31:0]              awaddr,
  input  wire logic [2:0]               awprot,
  input  wire logic                     awvalid,
  output logic                          awready,
  // AXI4-Lite write data
  input  wire logic [31:0]              wdata,
  input  wire logic [3:0]               wstrb,
  input  wire logic                     wvalid,
  output logic                          wready,
  // AXI4-Lite write response
  output logic [1:0]                    bresp,
  output logic                          bvalid,
  input  wire logic                     bready,
  // AXI4-Lite read address
  input  wire logic [31:0]              araddr,
  input  wire logic [2:0]               arprot,
  input  wire logic                     arvalid,
  output logic                          arready,
  // AXI4-Lite read data
  output logic [31:0]                   rdata,
  output logic [1:0]                    rresp,
  output logic                          rvalid,
  input  wire logic                     rready,
  // Texel request from the sampler
  input  wire texdec_pkg::texel_req_t   req,
  // Decoded texel back to the sampler
  output texdec_pkg::texel_rsp_t        rsp
);

  localparam int LAT = `DEC_LATENCY;

  // ----------------------------------------------------------------
  // State and decoder
  // ----------------------------------------------------------------
  texdec_pkg::top_state_t  s_r;
  texdec_pkg::top_state_t  s_nxt;
  texdec_pkg::argb_t       dec_argb;
  texdec_pkg::mode_t       dec_mode;
  logic [2:0]              dec_sel;

  // The decoder works on the registered request, so the colour path
  // is one full cycle of logic between two flops.
  texel_colour_decode u_dec (
    .blk   (s_r.s1.blk),
    .index (s_r.s1.index),
    .argb  (dec_argb),
    .mode  (dec_mode),
    .sel   (dec_sel)
  );

  // ----------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------
  // Unaligned or unknown addresses answer SLVERR with zero data.
  function automatic logic [33:0] read_word(input logic [7:0] a,
                                            input texdec_pkg::top_state_t st);
    case (a)
      `REG_CTRL:  return {`RESP_OKAY, 31'h0, st.enable};
      `REG_COUNT: return {`RESP_OKAY, st.count};
      `REG_MODE:  return {`RESP_OKAY, 30'h0, st.last_mode};
      default:    return {`RESP_SLVERR, 32'h0};
    endcase
  endfunction

  function automatic logic addr_known(input logic [7:0] a);
    return a == `REG_CTRL || a == `REG_COUNT || a == `REG_MODE;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Request pipeline, counters and the bus slave in one pass.
  always_comb begin
    s_nxt = s_r;
    // Requests are dropped while decoding is disabled; no stall exists,
    // so a dropped request never gets an answer.
    s_nxt.s1 = req;
    s_nxt.s1.valid = req.valid & s_r.enable;
    s_nxt.rsp.valid = s_r.s1.valid;
    if (s_r.s1.valid) begin
      s_nxt.rsp.argb = dec_argb;
      s_nxt.count = s_r.count + 32'h1;
      s_nxt.last_mode = dec_mode;
    end
    // Write address and data are taken independently.
    if (awvalid && s_r.awready) begin
      s_nxt.aw_held = 1'b1;
      s_nxt.waddr = awaddr[7:0];
    end
    if (wvalid && s_r.wready) begin
      s_nxt.w_held = 1'b1;
      s_nxt.wdata = wdata;
      s_nxt.wstrb = wstrb;
    end
    if (s_r.bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_nxt.aw_held && s_nxt.w_held && !s_r.bvalid) begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = addr_known(s_nxt.waddr) ? `RESP_OKAY : `RESP_SLVERR;
      if (s_nxt.waddr == `REG_CTRL && s_nxt.wstrb[0]) begin
        s_nxt.enable = s_nxt.wdata[`CTRL_EN_BIT];
      end
    end
    s_nxt.awready = !s_nxt.aw_held && !s_nxt.bvalid;
    s_nxt.wready = !s_nxt.w_held && !s_nxt.bvalid;
    // Read: one outstanding at a time.
    if (s_r.rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (arvalid && s_r.arready) begin
      s_nxt.rvalid = 1'b1;
      {s_nxt.rresp, s_nxt.rdata} = read_word(araddr[7:0], s_r);
    end
    s_nxt.arready = !s_nxt.rvalid;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Ready flags come up one cycle after reset, never during it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.enable <= `CTRL_EN_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs are taken straight from the state flops.
  assign awready = s_r.awready;
  assign wready  = s_r.wready;
  assign bvalid  = s_r.bvalid;
  assign bresp   = s_r.bresp;
  assign arready = s_r.arready;
  assign rvalid  = s_r.rvalid;
  assign rdata   = s_r.rdata;
  assign rresp   = s_r.rresp;
  assign rsp     = s_r.rsp;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence seq_taken;
    req.valid && s_r.enable;
  endsequence

  sequence seq_stage_hi;
    s_r.s1.valid && dec_mode == texdec_pkg::hi_precision_mode;
  endsequence

  sequence seq_stage_direct;
    s_r.s1.valid && dec_mode == texdec_pkg::direct_four_colour_mode;
  endsequence

  sequence seq_stage_split0;
    s_r.s1.valid && dec_mode == texdec_pkg::split_pair_mode && !s_r.s1.blk[`MIX_FLAG_BIT];
  endsequence

  // Mode decode from the top bits.
  chk_mode_hi: assert property (
    s_r.s1.valid && s_r.s1.blk[127:126] == 2'b00 |-> dec_mode == texdec_pkg::hi_precision_mode)
    else $error("top bits 00 not decoded as high precision");

  chk_mode_direct: assert property (
    s_r.s1.valid && s_r.s1.blk[127:125] == 3'b010
    |-> dec_mode == texdec_pkg::direct_four_colour_mode)
    else $error("top bits 010 not decoded as direct mode");

  chk_mode_split: assert property (
    s_r.s1.valid && s_r.s1.blk[127] |-> dec_mode == texdec_pkg::split_pair_mode)
    else $error("bit 127 set not decoded as split pair");

  // Fixed latency both ways.
  chk_fixed_latency: assert property (
    seq_taken |-> ##LAT rsp.valid)
    else $error("accepted request not answered at fixed latency");

  chk_no_spurious: assert property (
    rsp.valid |-> $past(req.valid, 2) && $past(s_r.enable, 2))
    else $error("response without a matching request");

  // High-precision selector position.
  chk_hi_selector: assert property (
    seq_stage_hi |-> dec_sel == 3'(s_r.s1.blk >> (8'(s_r.s1.index) * 8'd3)))
    else $error("high precision selector taken from wrong bits");

  // High-precision table end points and black entry.
  chk_hi_black: assert property (
    seq_stage_hi ##0 (dec_sel == `HI_BLACK_SEL) |=> rsp.valid && rsp.argb == '0)
    else $error("entry 7 not transparent black");

  chk_hi_colour0: assert property (
    seq_stage_hi ##0 (dec_sel == 3'h0) |=> rsp.argb == {`ALPHA_OPAQUE,
      texdec_pkg::widen555($past(s_r.s1.blk[`HI_C0_LSB +: `COL_W]))})
    else $error("entry 0 differs from widened colour 0");

  chk_hi_colour1: assert property (
    seq_stage_hi ##0 (dec_sel == 3'h6) |=> rsp.argb == {`ALPHA_OPAQUE,
      texdec_pkg::widen555($past(s_r.s1.blk[`HI_C1_LSB +: `COL_W]))})
    else $error("entry 6 differs from widened colour 1");

  // Direct mode returns the selected colour, opaque.
  chk_direct_entry: assert property (
    seq_stage_direct |=> rsp.argb == {`ALPHA_OPAQUE, texdec_pkg::widen555(
      $past(s_r.s1.blk[`QUAD_COL_LSB + 15 * dec_sel[1:0] +: `COL_W]))})
    else $error("direct mode colour or alpha wrong");

  chk_direct_sel: assert property (
    seq_stage_direct |-> dec_sel[1:0] == s_r.s1.blk[{s_r.s1.index, 1'b0} +: 2])
    else $error("direct mode selector taken from wrong bits");

  // Split pair entry 0 comes from the pair of the texel's half.
  chk_split_pair: assert property (
    seq_stage_split0 ##0 (dec_sel[1:0] == 2'h0) |=>
      rsp.argb.c.r == texdec_pkg::widen5($past(s_r.s1.index[4]) ?
        $past(s_r.s1.blk[108:104]) : $past(s_r.s1.blk[78:74])))
    else $error("split pair used the wrong colour pair");

  chk_split_opaque: assert property (
    seq_stage_split0 |=> rsp.argb.a == `ALPHA_OPAQUE)
    else $error("split pair entry not opaque");

  // Bus answers.
  chk_write_answer: assert property (
    awvalid && awready && wvalid && wready |=> bvalid)
    else $error("write not answered one cycle after both taken");

  chk_read_answer: assert property (
    arvalid && arready |=> rvalid && !arready)
    else $error("read not answered one cycle after address");

  chk_resp_hold: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before taken");

endmodule // texel_decoder_top

//--- texel_sampler_model.sv
// Requesting side of the texel port: one texel request per call.
module texel_sampler_model (
  // Clock
  input  wire logic                aclk,
  // Request towards the decoder
  output texdec_pkg::texel_req_t   req
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle at time zero so nothing is taken during reset.
  initial req = '{1'b0, 128'h0, 5'h0};

  // One request per edge, block and texel number held with the strobe.
  task automatic send(input logic [127:0] b, input logic [4:0] i);
    @(posedge aclk);
    req <= '{1'b1, b, i};
  endtask

  // Released lines toggle so a stale value can never pass for a live one.
  task automatic idle();
    @(posedge aclk);
    req <= '{1'b0, ~req.blk, ~req.index};
  endtask
endmodule // texel_sampler_model

//--- compressed_texture_block_decoder_tb_top.sv
`include "texdec_consts.svh"

module compressed_texture_block_decoder_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct {
    logic [31:0] argb;
    int          due;
  } exp_t;

  logic                   aclk;
  logic                   aresetn;
  logic [31:0]            awaddr, wdata, araddr;
  logic [3:0]             wstrb;
  logic                   awvalid, wvalid, bready, arvalid, rready;
  logic                   awready, wready, bvalid, arready, rvalid;
  logic [1:0]             bresp, rresp;
  logic [31:0]            rdata;
  texdec_pkg::texel_req_t req;
  texdec_pkg::texel_rsp_t rsp;
  exp_t                   q[$];
  int                     n_fail, checks_done, cyc, sent;
  int                     seed = 32'h85c931fb;
  logic                   en = 1'b1;

  // ----------------------------------------------------------------
  // Design and requester
  // ----------------------------------------------------------------
  texel_decoder_top texel_decoder_top_inst (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .req(req), .rsp(rsp));

  texel_sampler_model texel_sampler_model_inst (.aclk(aclk), .req(req));

  // Free-running clock, 5 ns period.
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=0x%h exp=0x%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // A wait that ran out is a mismatch and stops the run.
  task automatic hang();
    check(32'h0000dead, 32'h0);
    end_sim();
  endtask

  // ----------------------------------------------------------------
  // Expected colours, worked out independently of the design
  // ----------------------------------------------------------------
  function automatic logic [7:0] w5(input logic [4:0] c);
    return {c, c[4:2]};
  endfunction

  function automatic logic [23:0] e555(input logic [14:0] f);
    return {w5(f[14:10]), w5(f[9:5]), w5(f[4:0])};
  endfunction

  function automatic logic [23:0] e565(input logic [14:0] f, input logic l);
    return {w5(f[14:10]), f[9:5], l, f[9:8], w5(f[4:0])};
  endfunction

  // Per-channel weighted blend; integer division floors as required.
  function automatic logic [23:0] mix(input logic [23:0] a, input logic [23:0] c,
                                      input int wa, input int wc, input int rnd, input int dv);
    logic [23:0] r;
    for (int j = 0; j < 3; j++) r[8*j +: 8] = 8'((wa * a[8*j +: 8] + wc * c[8*j +: 8] + rnd) / dv);
    return r;
  endfunction

  function automatic logic [31:0] exp_texel(input logic [127:0] b, input logic [4:0] i);
    logic [14:0] f [4];
    logic [23:0] ca, cb;
    logic [2:0]  s;
    logic        p;
    for (int n = 0; n < 4; n++) f[n] = b[64 + 15 * n +: 15];
    p = i[4];
    s = {1'b0, b[2 * i +: 2]};
    if (b[127]) begin
      cb = e565(f[2 * p + 1], p ? b[126] : b[125]);
      if (!b[124]) begin
        ca = e565(f[2 * p], p ? b[33] ^ b[126] : b[1] ^ b[125]);
        if (s == 3'h1) return {8'hff, mix(ca, cb, 2, 1, 1, 3)};
        if (s == 3'h2) return {8'hff, mix(ca, cb, 1, 2, 1, 3)};
        return {8'hff, (s == 3'h0) ? ca : cb};
      end
      ca = e555(f[2 * p]);
      if (s == 3'h3) return 32'h0;
      if (s == 3'h1) return {8'hff, mix(ca, cb, 1, 1, 1, 2)};
      return {8'hff, (s == 3'h0) ? ca : cb};
    end
    if (b[126:125] == 2'b11) return 32'h0;
    if (b[126]) return {8'hff, e555(f[s[1:0]])};
    s = b[3 * i +: 3];
    if (s == 3'h7) return 32'h0;
    return {8'hff, mix(e555(b[110:96]), e555(b[125:111]), 6 - s, s, 3, 6)};
  endfunction

  // Mode 0 high precision, 1 direct, 2/3 split with flag clear/set, 4 unsupported.
  function automatic logic [127:0] shape(input logic [127:0] b, input int m,
                                         input logic [4:0] i, input logic [2:0] s);
    logic [127:0] r;
    r = b;
    case (m)
      0: r[127:126] = 2'b00;
      1: r[127:125] = 3'b010;
      2: r[127:124] = {1'b1, r[126:125], 1'b0};
      3: r[127:124] = {1'b1, r[126:125], 1'b1};
      default: r[127:125] = 3'b011;
    endcase
    if (m == 0) r[3 * i +: 3] = s;
    else r[2 * i +: 2] = s[1:0];
    return r;
  endfunction

  function automatic logic [127:0] rnd128();
    return {$random(seed), $random(seed), $random(seed), $random(seed)};
  endfunction

  // ----------------------------------------------------------------
  // Bus and texel drivers
  // ----------------------------------------------------------------
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d,
                        input logic [3:0] s, input logic [1:0] er);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      // Ready trails the response by a cycle, so a pending response is seen held.
      if (bvalid && bready) begin
        bready <= 1'b0;
        check({30'h0, bresp}, {30'h0, er});
        return;
      end
      if (bvalid) bready <= 1'b1;
    end
    hang();
  endtask

  task automatic axi_rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        check(rdata, d);
        check({30'h0, rresp}, {30'h0, er});
        return;
      end
    end
    hang();
  endtask

  // Answer due three pre-edge counts on: taken next edge, seen high two edges later.
  task automatic issue(input logic [127:0] b, input logic [4:0] i);
    exp_t e;
    texel_sampler_model_inst.send(b, i);
    e.argb = exp_texel(b, i);
    e.due  = cyc + 3;
    if (en) begin
      q.push_back(e);
      sent++;
    end
  endtask

  task automatic drain(input int n);
    repeat (n) texel_sampler_model_inst.idle();
  endtask

  // Answers must come exactly on time, in order, and never unasked.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (aresetn) begin
      if (q.size() != 0 && q[0].due == cyc) begin
        check({31'h0, rsp.valid}, 32'h1);
        check(rsp.argb, q[0].argb);
        void'(q.pop_front());
      end else if (rsp.valid !== 1'b0) check({31'h0, rsp.valid}, 32'h0);
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    static int ix [4] = '{0, 15, 16, 31};
    {awaddr, wdata, araddr, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    aresetn = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    check({31'h0, rsp.valid}, 32'h0);
    check(rsp.argb, 32'h0);
    axi_rd(`REG_CTRL, 32'h1, `RESP_OKAY);
    axi_rd(`REG_COUNT, 32'h0, `RESP_OKAY);
    // Every mode, boundary texels and every selector value, back to back.
    for (int m = 0; m < 5; m++) begin
      foreach (ix[k]) for (int s = 0; s < 8; s++) issue(shape(rnd128(), m, 5'(ix[k]), 3'(s)), 5'(ix[k]));
      drain(4);
      axi_rd(`REG_MODE, (m < 2) ? m : ((m < 4) ? 2 : 3), `RESP_OKAY);
    end
    // Random blocks of every mode with occasional gaps.
    repeat (400) begin
      issue(rnd128(), 5'($random(seed)));
      if (($random(seed) & 7) == 0) drain(1);
    end
    drain(4);
    axi_rd(`REG_COUNT, sent, `RESP_OKAY);
    // Refused and ignored accesses.
    axi_wr(`REG_CTRL, 32'h0, 4'h0, `RESP_OKAY);
    axi_rd(`REG_CTRL, 32'h1, `RESP_OKAY);
    axi_wr(`REG_COUNT, 32'h5, 4'hf, `RESP_OKAY);
    axi_rd(`REG_COUNT, sent, `RESP_OKAY);
    axi_wr(32'h0000000c, 32'h1, 4'hf, `RESP_SLVERR);
    axi_rd(32'h0000000c, 32'h0, `RESP_SLVERR);
    axi_rd(32'h00000002, 32'h0, `RESP_SLVERR);
    // Disabled requests are dropped without an answer.
    axi_wr(`REG_CTRL, 32'h0, 4'h1, `RESP_OKAY);
    en = 1'b0;
    repeat (10) issue(rnd128(), 5'($random(seed)));
    drain(4);
    axi_rd(`REG_COUNT, sent, `RESP_OKAY);
    axi_wr(`REG_CTRL, 32'h1, 4'h1, `RESP_OKAY);
    en = 1'b1;
    repeat (5) issue(rnd128(), 5'($random(seed)));
    drain(4);
    axi_rd(`REG_COUNT, sent, `RESP_OKAY);
    check(q.size(), 32'h0);
    end_sim();
  end
endmodule // compressed_texture_block_decoder_tb_top
